// file: hw/fp_load_decode_ea.sv
// Decoder and sequencer for quad indexed and single displacement floating-point loads.
// Assumes the core holds issue until done pulses, and memory answers each read with one rdValid.
module fp_load_decode_ea #(
   parameter bit QUAD_SUPPORT = 1'b1
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Instruction issue
   input  wire logic        issueValid,
   input  wire logic [31:0] instr,
   output logic             issueReady,
   output logic             illegal,
   output logic             done,
   // General register read ports, addressed by the decoded fields
   output logic [4:0]       baseRegAddr,
   output logic [4:0]       indexRegAddr,
   input  wire logic [31:0] baseRegData,
   input  wire logic [31:0] indexRegData,
   // Memory read request and answer
   output logic             rdReq,
   output logic [31:0]      effectiveAddress,
   output logic             rdDouble,
   input  wire logic        rdValid,
   input  wire logic [63:0] rdData,
   input  wire logic        alignFault,
   input  wire logic        storageFault,
   // Float register write port
   output logic             floatWrEn,
   output logic [4:0]       floatWrAddr,
   output logic [63:0]      floatWrData,
   // General register writeback of the address
   output logic             genWrEn,
   output logic [4:0]       genWrAddr,
   output logic [31:0]      genWrData,
   // Status and condition register writes, never used by these loads
   output logic             fpscrWrEn,
   output logic             cr0WrEn
);
   typedef struct packed {
      fp_load_pkg::state_e st;
      logic        quad;
      logic        upd;
      logic        fault;
      logic [4:0]  tgt;
      logic [4:0]  base;
      logic [31:0] ea;
      logic        fwe;
      logic [4:0]  fwa;
      logic [63:0] fwd;
      logic        gwe;
      logic        dn;
      logic        ill;
   } state_s;

   state_s cur_r, cur_nxt;

   function automatic logic [63:0] singleToDouble(input logic [31:0] s);
      logic [10:0] e;
      e = {3'h0, s[30:23]} + fp_load_pkg::DBL_BIAS_ADJ;
      if (s[30:23] == 8'h00)
         singleToDouble = {s[31], 63'h0};
      else if (s[30:23] == 8'hFF)
         singleToDouble = {s[31], 11'h7FF, s[22:0], 29'h0};
      else
         singleToDouble = {s[31], e, s[22:0], 29'h0};
   endfunction : singleToDouble

   logic [5:0]  opc;
   logic [9:0]  xop;
   logic        isQuadUpd, isQuad, isSgl, isSglUpd, legal;
   logic [31:0] dispExt;

   assign opc = instr[fp_load_pkg::OPC_LSB +: 6];
   assign xop = instr[fp_load_pkg::XOP_LSB +: 10];
   assign isQuadUpd = QUAD_SUPPORT && opc == fp_load_pkg::OPC_INDEXED && xop == fp_load_pkg::XOP_QUAD_UPD; // RQ1 RQ7
   assign isQuad    = QUAD_SUPPORT && opc == fp_load_pkg::OPC_INDEXED && xop == fp_load_pkg::XOP_QUAD;     // RQ2 RQ7
   assign isSgl     = opc == fp_load_pkg::OPC_SINGLE;     // RQ8
   assign isSglUpd  = opc == fp_load_pkg::OPC_SINGLE_UPD; // RQ9
   assign legal     = isQuadUpd | isQuad | isSgl | isSglUpd;
   assign dispExt   = {{16{instr[15]}}, instr[15:0]};
   assign baseRegAddr  = instr[fp_load_pkg::BASE_LSB +: 5];
   assign indexRegAddr = instr[fp_load_pkg::IDX_LSB +: 5];

   always_comb begin
      logic [31:0] offs;
      offs = 32'h0;
      cur_nxt = cur_r;
      cur_nxt.fwe = 1'b0;
      cur_nxt.gwe = 1'b0;
      cur_nxt.dn  = 1'b0;
      cur_nxt.ill = 1'b0;
      case (cur_r.st)
         fp_load_pkg::ST_IDLE: begin
            if (issueValid) begin
               if (!legal) begin
                  cur_nxt.ill = 1'b1;
                  cur_nxt.dn  = 1'b1;
               end else begin
                  offs = (isQuad | isQuadUpd) ? indexRegData : dispExt;
                  // Base field zero means literal zero, not register 0
                  cur_nxt.ea    = (baseRegAddr != 5'h00) ? baseRegData + offs : offs; // RQ3 RQ10
                  cur_nxt.quad  = isQuad | isQuadUpd;
                  cur_nxt.upd   = isQuadUpd | isSglUpd; // RQ12
                  cur_nxt.tgt   = instr[fp_load_pkg::TGT_LSB +: 5];
                  cur_nxt.base  = baseRegAddr;
                  cur_nxt.fault = 1'b0;
                  cur_nxt.st    = fp_load_pkg::ST_RD0;
               end
            end
         end
         fp_load_pkg::ST_RD0: begin
            if (rdValid) begin
               cur_nxt.fwe   = !(alignFault | storageFault);
               cur_nxt.fwa   = cur_r.tgt;
               cur_nxt.fwd   = cur_r.quad ? rdData : singleToDouble(rdData[31:0]); // RQ4 RQ8 RQ9
               cur_nxt.fault = alignFault | storageFault;
               if (cur_r.quad && !(alignFault | storageFault))
                  cur_nxt.st = fp_load_pkg::ST_RD1;
               else
                  cur_nxt.st = fp_load_pkg::ST_WB;
            end
         end
         fp_load_pkg::ST_RD1: begin
            if (rdValid) begin
               cur_nxt.fwe   = !(alignFault | storageFault);
               // 5-bit add wraps register 31 to register 0
               cur_nxt.fwa   = cur_r.tgt + 5'h01; // RQ4
               cur_nxt.fwd   = rdData;
               cur_nxt.fault = alignFault | storageFault;
               cur_nxt.st    = fp_load_pkg::ST_WB;
            end
         end
         fp_load_pkg::ST_WB: begin
            cur_nxt.gwe = cur_r.upd && cur_r.base != 5'h00 && !cur_r.fault; // RQ5 RQ11 RQ12
            cur_nxt.st  = fp_load_pkg::ST_DONE;
         end
         fp_load_pkg::ST_DONE: begin
            cur_nxt.dn = 1'b1;
            cur_nxt.st = fp_load_pkg::ST_IDLE;
         end
         default: cur_nxt.st = fp_load_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cur_r <= '{st: fp_load_pkg::ST_IDLE, default: '0};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign issueReady = cur_r.st == fp_load_pkg::ST_IDLE;
   assign illegal    = cur_r.ill;
   assign done       = cur_r.dn;
   assign rdReq      = cur_r.st == fp_load_pkg::ST_RD0 || cur_r.st == fp_load_pkg::ST_RD1;
   assign rdDouble   = cur_r.quad;
   assign effectiveAddress = (cur_r.st == fp_load_pkg::ST_RD1) ? cur_r.ea + fp_load_pkg::DWORD_STEP : cur_r.ea; // RQ4
   assign floatWrEn   = cur_r.fwe;
   assign floatWrAddr = cur_r.fwa;
   assign floatWrData = cur_r.fwd;
   assign genWrEn     = cur_r.gwe;
   assign genWrAddr   = cur_r.base;
   assign genWrData   = cur_r.ea;
   // Record bit is not decoded and is deliberately ignored
   assign fpscrWrEn = 1'b0; // RQ6
   assign cr0WrEn   = 1'b0; // RQ6

   chk_base_write_cond: assert property (@(posedge mclk) disable iff (!rst_b)
      genWrEn |-> (cur_r.upd && genWrAddr != 5'h00 && !cur_r.fault)) else $error("base write without cause"); // RQ5
   chk_fault_no_update: assert property (@(posedge mclk) disable iff (!rst_b)
      (rdValid && rdReq && (alignFault || storageFault)) |-> ##2 !genWrEn) else $error("update after fault"); // RQ11
   chk_noupd_no_write: assert property (@(posedge mclk) disable iff (!rst_b)
      (issueReady && issueValid && (isQuad || isSgl)) |-> ##1 (!genWrEn)[*4]) else $error("non-update form wrote base"); // RQ12
   chk_pair_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
      (cur_r.st == fp_load_pkg::ST_RD1 && rdValid && floatWrEn == 1'b0 && !alignFault && !storageFault)
      |-> ##1 (floatWrEn && floatWrAddr == cur_r.tgt + 5'h01)) else $error("second register wrong"); // RQ4
   chk_second_addr: assert property (@(posedge mclk) disable iff (!rst_b)
      cur_r.st == fp_load_pkg::ST_RD1 |-> effectiveAddress == $past(effectiveAddress) + 32'h8
      || $past(cur_r.st) == fp_load_pkg::ST_RD1) else $error("second address not plus eight"); // RQ4
   chk_no_status_write: assert property (@(posedge mclk) disable iff (!rst_b)
      !fpscrWrEn && !cr0WrEn) else $error("status register written"); // RQ6
   chk_quad_variant: assert property (@(posedge mclk) disable iff (!rst_b)
      (issueReady && issueValid && !QUAD_SUPPORT && opc == fp_load_pkg::OPC_INDEXED) |-> ##1 illegal)
      else $error("quad accepted without support"); // RQ7
   chk_single_ea: assert property (@(posedge mclk) disable iff (!rst_b)
      (issueReady && issueValid && (isSgl || isSglUpd)) |-> ##1
      effectiveAddress == (($past(baseRegAddr) != 5'h00) ? $past(baseRegData) + $past(dispExt) : $past(dispExt)))
      else $error("single address wrong"); // RQ10
   chk_quad_ea: assert property (@(posedge mclk) disable iff (!rst_b)
      (issueReady && issueValid && (isQuad || isQuadUpd)) |-> ##1
      effectiveAddress == (($past(baseRegAddr) != 5'h00) ? $past(baseRegData) + $past(indexRegData)
      : $past(indexRegData))) else $error("quad address wrong"); // RQ3
   chk_decode_quad: assert property (@(posedge mclk) disable iff (!rst_b)
      (issueReady && issueValid && isQuadUpd) |-> ##1 (rdReq && rdDouble)) else $error("quad update not decoded"); // RQ1
   chk_decode_quadx: assert property (@(posedge mclk) disable iff (!rst_b)
      (issueReady && issueValid && isQuad) |-> ##1 (rdReq && rdDouble && !cur_r.upd)) else $error("quad not decoded"); // RQ2
   chk_single_conv: assert property (@(posedge mclk) disable iff (!rst_b)
      (cur_r.st == fp_load_pkg::ST_RD0 && rdValid && !cur_r.quad && !alignFault && !storageFault
      && rdData[30:23] == 8'h7F) |-> ##1 (floatWrEn && floatWrData[62:52] == 11'h3FF)) else $error("conversion wrong"); // RQ8
   chk_single_upd: assert property (@(posedge mclk) disable iff (!rst_b)
      (issueReady && issueValid && isSglUpd) |-> ##1 (rdReq && !rdDouble && cur_r.upd)) else $error("single update wrong"); // RQ9
endmodule : fp_load_decode_ea

// file: hw/fp_load_pkg.sv
// Constants, field positions and states for the floating-point load decoder.
// Assumes a 32-bit core with big-endian bit numbering in the instruction word (bit 0 is the MSB).
// Contract
// RQ1 - Decode opcode 31, extended 823 as quad load with update indexed.
// RQ2 - Decode opcode 31, extended 791 as quad load indexed.
// RQ3 - Indexed quad address is base plus index, or index alone if base field zero.
// RQ4 - Quad writes doubleword at address to target, address plus eight to next, wrapping.
// RQ5 - Quad update form writes address into base register when base field nonzero.
// RQ6 - No form touches floating status register or condition field 0, record bit ignored.
// RQ7 - Quad forms accepted only when the variant supports quad loads.
// RQ8 - Opcode 48 loads single word, converts to double, writes target register.
// RQ9 - Opcode 49 does the same conversion and write, with update.
// RQ10 - Single address is sign-extended displacement plus base, or displacement alone.
// RQ11 - Single update writes base only when base nonzero and no alignment or storage fault.
// RQ12 - Non-update forms never write the base register.
package fp_load_pkg;
   localparam logic [5:0] OPC_INDEXED    = 6'h1F;
   localparam logic [5:0] OPC_SINGLE     = 6'h30;
   localparam logic [5:0] OPC_SINGLE_UPD = 6'h31;
   localparam logic [9:0] XOP_QUAD_UPD   = 10'h337;
   localparam logic [9:0] XOP_QUAD       = 10'h317;
   // Positions as LSB indices of a [31:0] vector
   localparam int OPC_LSB  = 26;
   localparam int TGT_LSB  = 21;
   localparam int BASE_LSB = 16;
   localparam int IDX_LSB  = 11;
   localparam int XOP_LSB  = 1;
   localparam logic [31:0] DWORD_STEP = 32'h0000_0008;
   localparam logic [4:0]  LAST_FREG  = 5'h1F;
   localparam logic [10:0] DBL_BIAS_ADJ = 11'h380;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_RD0   = 5'b00010,
      ST_RD1   = 5'b00100,
      ST_WB    = 5'b01000,
      ST_DONE  = 5'b10000
   } state_e;
endpackage : fp_load_pkg

// file: test/fp_load_decode_ea_bench.sv
// Self-checking bench for the floating-point load decoder.
// Assumes the memory model above; register file values come from the bench.
module fp_load_decode_ea_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rst_b, issueValid, issueReady, illegal, done, rdReq, rdDouble, rdValid;
   logic        alignFault, storageFault, floatWrEn, genWrEn, fpscrWrEn, cr0WrEn;
   logic [31:0] instr, baseRegData, indexRegData, effectiveAddress, genWrData, seed;
   logic [4:0]  baseRegAddr, indexRegAddr, floatWrAddr, genWrAddr;
   logic [63:0] rdData, floatWrData;
   logic [1:0]  waitCycles, faultCmd;
   logic [69:0] expQ[$];
   int          err_count, total_checks;
   fp_load_decode_ea fp_load_decode_ea_inst (.mclk, .rst_b, .issueValid, .instr, .issueReady, .illegal, .done,
      .baseRegAddr, .indexRegAddr, .baseRegData, .indexRegData, .rdReq, .effectiveAddress, .rdDouble, .rdValid,
      .rdData, .alignFault, .storageFault, .floatWrEn, .floatWrAddr, .floatWrData, .genWrEn, .genWrAddr,
      .genWrData, .fpscrWrEn, .cr0WrEn);
   fp_load_mem_model fp_load_mem_model_inst (.mclk, .rst_b, .rdReq, .effectiveAddress, .waitCycles, .faultCmd,
      .rdValid, .rdData, .alignFault, .storageFault);
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [63:0] dword(input logic [31:0] a);
      return {a ^ 32'h5A5A_5A5A, 9'h07F, a[22:0]};
   endfunction : dword
   task automatic check(input logic [69:0] seen, input logic [69:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic run(input logic [5:0] opc, input logic [9:0] xop, input logic [4:0] tgt, input logic [4:0] ra,
                      input logic [1:0] flt, input logic expIll);
      logic [31:0] b, x, ea;
      logic        quad, upd;
      int          n;
      seed = lfsr(seed);
      b = seed;
      seed = lfsr(seed);
      x = seed;
      quad = (opc == fp_load_pkg::OPC_INDEXED);
      upd = quad ? (xop == fp_load_pkg::XOP_QUAD_UPD) : (opc == fp_load_pkg::OPC_SINGLE_UPD);
      ea = (ra != 5'h0 ? b : 32'h0) + (quad ? x : {{16{x[15]}}, x[15:0]});
      if (!expIll && flt == 2'h0) begin
         if (quad) begin
            expQ.push_back({1'b1, tgt, dword(ea)});
            expQ.push_back({1'b1, tgt + 5'h1, dword(ea + 32'h8)});
         end else expQ.push_back({1'b1, tgt, 12'h3FF, ea[22:0], 29'h0});
         if (upd && ra != 5'h0) expQ.push_back({1'b0, ra, 32'h0, ea});
      end
      faultCmd <= flt;
      waitCycles <= seed[1:0];
      // Record bit always set on indexed forms
      instr <= quad ? {opc, tgt, ra, b[4:0], xop, 1'b1} : {opc, tgt, ra, x[15:0]};
      baseRegData <= b;
      indexRegData <= x;
      issueValid <= 1'b1;
      n = 0;
      do begin @(posedge mclk); n++; end while (issueReady !== 1'b1 && n < 50);
      if (issueReady !== 1'b1) begin
         err_count++;
         give_verdict();
      end
      issueValid <= 1'b0;
      n = 0;
      do begin @(posedge mclk); n++; end while (done !== 1'b1 && n < 50);
      if (done !== 1'b1) begin
         err_count++;
         give_verdict();
      end
      check(illegal, expIll);
      check({fpscrWrEn, cr0WrEn}, 2'h0);
   endtask : run
   always @(posedge mclk) begin
      if (rst_b && floatWrEn) check({1'b1, floatWrAddr, floatWrData}, expQ.size() ? expQ.pop_front() : '1);
      if (rst_b && genWrEn) check({1'b0, genWrAddr, 32'h0, genWrData}, expQ.size() ? expQ.pop_front() : '1);
   end
   initial begin
      logic [5:0] opcT[4];
      logic [9:0] xopT[4];
      opcT = '{fp_load_pkg::OPC_SINGLE, fp_load_pkg::OPC_SINGLE_UPD, 6'h1F, 6'h1F};
      xopT = '{10'h0, 10'h0, fp_load_pkg::XOP_QUAD, fp_load_pkg::XOP_QUAD_UPD};
      {rst_b, issueValid, instr, baseRegData, indexRegData, waitCycles, faultCmd} = '0;
      seed = 32'h9ACC_A957;
      err_count = 0;
      total_checks = 0;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      // Back-to-back issue; zero base first, then random, four quad wraps at 31
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         run(opcT[i % 4], xopT[i % 4], (i % 8 > 5) ? 5'h1F : seed[4:0], (i < 4) ? 5'h0 : seed[9:5], 2'h0, 1'b0);
      end
      run(fp_load_pkg::OPC_SINGLE_UPD, 10'h0, 5'h7, 5'h3, 2'h1, 1'b0);
      run(fp_load_pkg::OPC_SINGLE_UPD, 10'h0, 5'h7, 5'h3, 2'h2, 1'b0);
      run(6'h1F, fp_load_pkg::XOP_QUAD_UPD, 5'h1F, 5'h3, 2'h2, 1'b0);
      run(6'h1F, 10'h217, 5'h4, 5'h3, 2'h0, 1'b1);
      run(6'h38, 10'h0, 5'h4, 5'h3, 2'h0, 1'b1);
      check(expQ.size(), 70'h0);
      give_verdict();
   end
endmodule : fp_load_decode_ea_bench

// file: test/fp_load_mem_model.sv
// Data memory model for the floating-point load decoder.
// Assumes each request stands until rdValid; fault bits are set by the bench.
module fp_load_mem_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Read side
   input  wire logic        rdReq,
   input  wire logic [31:0] effectiveAddress,
   input  wire logic [1:0]  waitCycles,
   input  wire logic [1:0]  faultCmd,
   output logic             rdValid,
   output logic [63:0]      rdData,
   output logic             alignFault,
   output logic             storageFault
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] cnt;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdValid <= 1'b0;
         cnt <= 2'h0;
         rdData <= 64'h0;
         alignFault <= 1'b0;
         storageFault <= 1'b0;
      end else if (rdValid || !rdReq) begin
         // Stale data is inverted so a late capture cannot match
         rdValid <= 1'b0;
         cnt <= 2'h0;
         rdData <= ~rdData;
         alignFault <= 1'b0;
         storageFault <= 1'b0;
      end else if (cnt == waitCycles) begin
         rdValid <= 1'b1;
         rdData <= {effectiveAddress ^ 32'h5A5A_5A5A, 9'h07F, effectiveAddress[22:0]};
         alignFault <= faultCmd[0];
         storageFault <= faultCmd[1];
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule : fp_load_mem_model
